// File: hdl/cpo_ctrl.sv
// auxiliary clock output, divided reference outputs and pll pin override
// Overview of operation
// - the auxiliary output and its divider stay off while the enable bit 7 is clear.
// - select 0,1,2 give 16,32,64 UI clocks, 3 the timestamp, 4 to 7 are reserved.
// - selects up to 2 come from the serializer, so a serializer reinit restarts them.
// - override bit 7 clear takes pll enable, reference type and outputs from pins.
// - with override set, bits 5:4 turn output D off or give the reference over 1, 2, 4.
// - with override clear, output D follows the two clock config pins.
// - output D never runs unless output C is running.
// - bits 3:2 set output C the same way with override set, else the config pins.
// - with override set, bit 1 selects the single-ended reference input.
// - with override set, bit 0 enables the pll.
`default_nettype none
module cpo_ctrl
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic ui_tick,
    input wire logic ser_reinit,
    input wire logic ref_tick,
    input wire logic pll_enable_pin,
    input wire logic single_ended_ref_pin,
    input wire logic clock_config_pin0,
    input wire logic clock_config_pin1,
    input wire logic timestamp_input,
    output logic aux_clock_pin,
    output logic ref_out_c,
    output logic ref_out_d,
    output logic pll_enable,
    output logic single_ended_ref_clock
);
    import cpo_pkg::*;

    logic [7:0] aux_ctrl_r;
    logic [7:0] pll_ovr_r;
    logic [7:0] trim_r;
    logic [7:0] reg_rdata_r;
    logic [CPO_NUM_PINS-1:0] sync1_r;
    logic [CPO_NUM_PINS-1:0] sync2_r;
    logic aux_clock_r;
    logic aux_clock_nxt;
    logic ref_c_r;
    logic ref_d_r;
    logic pll_en_r;
    logic pll_en_nxt;
    logic se_ref_r;
    logic se_ref_nxt;
    wire logic [CPO_NUM_PINS-1:0] pins_w;
    wire cpo_aux_sel_t aux_sel_w;
    wire logic aux_en_w;
    wire logic aux_serdes_w;
    wire logic ovr_en_w;
    wire logic [1:0] cfg_mode_w;
    wire logic [1:0] c_mode_w;
    wire logic [1:0] d_mode_w;
    wire logic c_on_w;
    wire logic d_on_w;
    wire logic [5:0] aux_half_w;
    wire logic [7:0] status_w;
    wire logic [7:0] rd_mux_w;

    cpo_div_if dif [3] ();

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    assign pins_w = {timestamp_input, clock_config_pin1, clock_config_pin0,
                     single_ended_ref_pin, pll_enable_pin};

    genvar gi;
    generate
        for (gi = 0; gi < CPO_NUM_PINS; gi++)
        begin : g_sync
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                end
                else
                begin
                    sync1_r[gi] <= pins_w[gi];
                    sync2_r[gi] <= sync1_r[gi];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            aux_ctrl_r <= CPO_RST_AUX_CTRL;
        else if (reg_wr && reg_addr == CPO_ADDR_AUX_CTRL)
            aux_ctrl_r <= reg_wdata;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            pll_ovr_r <= CPO_RST_PLL_OVR;
        else if (reg_wr && reg_addr == CPO_ADDR_PLL_OVR)
            pll_ovr_r <= reg_wdata;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            trim_r <= CPO_RST_TRIM;
        else if (reg_wr && reg_addr == CPO_ADDR_TRIM)
            trim_r <= reg_wdata;
    end

    assign status_w = {aux_en_w, 3'h0, d_on_w, c_on_w, se_ref_r, pll_en_r};
    assign rd_mux_w = (reg_addr == CPO_ADDR_AUX_CTRL) ? aux_ctrl_r :
                      (reg_addr == CPO_ADDR_PLL_OVR) ? pll_ovr_r :
                      (reg_addr == CPO_ADDR_TRIM) ? trim_r :
                      (reg_addr == CPO_ADDR_STATUS) ? status_w : 8'h00;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            reg_rdata_r <= 8'h00;
        else if (reg_rd)
            reg_rdata_r <= rd_mux_w;
    end

    // ----------------------------------------------------------------
    // auxiliary output
    // ----------------------------------------------------------------
    assign aux_en_w = aux_ctrl_r[CPO_AUX_EN_BIT];
    assign aux_sel_w = cpo_aux_sel_t'(aux_ctrl_r[CPO_AUX_SEL_LSB +: 3]);
    assign aux_serdes_w = aux_en_w && (aux_ctrl_r[CPO_AUX_SEL_LSB +: 3] <= 3'h2);
    assign aux_half_w = (aux_sel_w == CPO_AUX_UI64) ? CPO_HALF_UI64 :
                        (aux_sel_w == CPO_AUX_UI32) ? CPO_HALF_UI32 : CPO_HALF_UI16;

    assign dif[0].enable = aux_serdes_w;
    assign dif[0].restart = ser_reinit;
    assign dif[0].tick = ui_tick;
    assign dif[0].half = aux_half_w;

    always_comb
    begin
        aux_clock_nxt = 1'b0;
        if (aux_en_w)
        begin
            case (aux_sel_w)
                CPO_AUX_UI16, CPO_AUX_UI32, CPO_AUX_UI64: aux_clock_nxt = dif[0].clk_out;
                CPO_AUX_TS: aux_clock_nxt = sync2_r[CPO_PIN_TS];
                default: aux_clock_nxt = 1'b0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // pll override and reference outputs
    // ----------------------------------------------------------------
    assign ovr_en_w = pll_ovr_r[CPO_OVR_EN_BIT];
    assign cfg_mode_w = {sync2_r[CPO_PIN_CFG1], sync2_r[CPO_PIN_CFG0]};
    assign c_mode_w = ovr_en_w ? pll_ovr_r[CPO_REF_C_LSB +: 2] : cfg_mode_w;
    assign d_mode_w = ovr_en_w ? pll_ovr_r[CPO_REF_D_LSB +: 2] : cfg_mode_w;
    assign c_on_w = c_mode_w != CPO_REF_OFF;
    assign d_on_w = c_on_w && (d_mode_w != CPO_REF_OFF);
    assign pll_en_nxt = ovr_en_w ? pll_ovr_r[CPO_PLL_EN_OVR_BIT] : sync2_r[CPO_PIN_PLL_EN];
    assign se_ref_nxt = ovr_en_w ? pll_ovr_r[CPO_SE_OVR_BIT] : sync2_r[CPO_PIN_SE];

    assign dif[1].enable = c_on_w;
    assign dif[1].restart = 1'b0;
    assign dif[1].tick = ref_tick;
    assign dif[1].half = cpo_ref_half(c_mode_w);
    assign dif[2].enable = d_on_w;
    assign dif[2].restart = 1'b0;
    assign dif[2].tick = ref_tick;
    assign dif[2].half = cpo_ref_half(d_mode_w);

    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_div
            cpo_div u_div (
                .clk(clk),
                .reset_n(reset_n),
                .d(dif[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // output flops
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            aux_clock_r <= 1'b0;
            ref_c_r <= 1'b0;
            ref_d_r <= 1'b0;
            pll_en_r <= 1'b0;
            se_ref_r <= 1'b0;
        end
        else
        begin
            aux_clock_r <= aux_clock_nxt;
            ref_c_r <= dif[1].clk_out;
            ref_d_r <= dif[2].clk_out;
            pll_en_r <= pll_en_nxt;
            se_ref_r <= se_ref_nxt;
        end
    end

    assign reg_rdata = reg_rdata_r;
    assign aux_clock_pin = aux_clock_r;
    assign ref_out_c = ref_c_r;
    assign ref_out_d = ref_d_r;
    assign pll_enable = pll_en_r;
    assign single_ended_ref_clock = se_ref_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_aux_off_low: assert property (
        @(posedge clk) disable iff (!reset_n) !aux_en_w |=> !aux_clock_pin)
        else $error("aux output active while disabled");
    a_aux_rsvd_low: assert property (
        @(posedge clk) disable iff (!reset_n)
        (aux_ctrl_r[CPO_AUX_SEL_LSB +: 3] >= 3'h4) |=> !aux_clock_pin)
        else $error("aux output active on reserved select");
    a_aux_ts_follow: assert property (
        @(posedge clk) disable iff (!reset_n)
        (aux_en_w && aux_sel_w == CPO_AUX_TS) |=> aux_clock_pin == $past(sync2_r[CPO_PIN_TS]))
        else $error("aux output not following timestamp");
    a_reinit_restart: assert property (
        @(posedge clk) disable iff (!reset_n)
        (aux_serdes_w && ser_reinit) |-> ##2 !aux_clock_pin)
        else $error("serializer reinit did not restart aux clock");
    a_pll_en_pin: assert property (
        @(posedge clk) disable iff (!reset_n)
        !ovr_en_w |=> pll_enable == $past(sync2_r[CPO_PIN_PLL_EN]))
        else $error("pll enable not from pin");
    a_pll_en_ovr: assert property (
        @(posedge clk) disable iff (!reset_n)
        ovr_en_w |=> pll_enable == $past(pll_ovr_r[CPO_PLL_EN_OVR_BIT]))
        else $error("pll enable not from register");
    a_se_ref_ovr: assert property (
        @(posedge clk) disable iff (!reset_n)
        ovr_en_w |=> single_ended_ref_clock == $past(pll_ovr_r[CPO_SE_OVR_BIT]))
        else $error("single-ended select not from register");
    a_d_needs_c: assert property (
        @(posedge clk) disable iff (!reset_n) (!c_on_w)[*2] |=> !ref_out_d)
        else $error("output D running without output C");
    a_d_from_cfg: assert property (
        @(posedge clk) disable iff (!reset_n)
        (!ovr_en_w && cfg_mode_w == CPO_REF_OFF)[*2] |=> !ref_out_d)
        else $error("output D not following config pins");
    a_c_off_ovr: assert property (
        @(posedge clk) disable iff (!reset_n)
        (ovr_en_w && pll_ovr_r[CPO_REF_C_LSB +: 2] == CPO_REF_OFF)[*2] |=> !ref_out_c)
        else $error("output C running while set off");
    a_d_off_ovr: assert property (
        @(posedge clk) disable iff (!reset_n)
        (ovr_en_w && pll_ovr_r[CPO_REF_D_LSB +: 2] == CPO_REF_OFF)[*2] |=> !ref_out_d)
        else $error("output D running while set off");

    c_aux_ui_clock: cover property (@(posedge clk) disable iff (!reset_n)
        aux_serdes_w && $rose(aux_clock_pin));
    c_aux_ts_mode: cover property (@(posedge clk) disable iff (!reset_n)
        aux_en_w && aux_sel_w == CPO_AUX_TS && $rose(aux_clock_pin));
    c_ovr_d_running: cover property (@(posedge clk) disable iff (!reset_n)
        ovr_en_w && $rose(ref_out_d));
    c_reinit_hit: cover property (@(posedge clk) disable iff (!reset_n)
        aux_serdes_w && ser_reinit);
endmodule : cpo_ctrl
`default_nettype wire

// File: hdl/cpo_div.sv
// tick-counting divider with a half period set by its controller
`default_nettype none
module cpo_div
(
    input wire logic clk,
    input wire logic reset_n,
    cpo_div_if.div d
);
    import cpo_pkg::*;

    logic [5:0] count_r;
    logic [5:0] count_nxt;
    logic out_r;
    wire logic last_w;
    wire logic hold_w;

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    assign last_w = count_r >= (d.half - 6'h01);
    assign hold_w = !d.enable || d.restart;
    assign count_nxt = last_w ? 6'h00 : count_r + 6'h01;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count_r <= 6'h00;
            out_r <= 1'b0;
        end
        else if (hold_w)
        begin
            count_r <= 6'h00;
            out_r <= 1'b0;
        end
        else if (d.tick)
        begin
            count_r <= count_nxt;
            out_r <= last_w ? !out_r : out_r;
        end
    end

    assign d.clk_out = out_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_div_toggle_edge: assert property (
        @(posedge clk) disable iff (!reset_n)
        (!hold_w && d.tick && last_w) |=> (out_r != $past(out_r)))
        else $error("divider missed its toggle");
    a_div_hold_edge: assert property (
        @(posedge clk) disable iff (!reset_n)
        (!hold_w && !(d.tick && last_w)) |=> $stable(out_r))
        else $error("divider toggled off its count");
endmodule : cpo_div
`default_nettype wire

// File: hdl/cpo_div_if.sv
// control and output of one tick-counting clock divider
`default_nettype none
interface cpo_div_if;
    logic enable;
    logic restart;
    logic tick;
    logic [5:0] half;
    logic clk_out;
    modport ctrl (output enable, output restart, output tick, output half, input clk_out);
    modport div (input enable, input restart, input tick, input half, output clk_out);
endinterface : cpo_div_if
`default_nettype wire

// File: hdl/cpo_pkg.sv
// constants and types for the clock output and pll override control
`default_nettype none
package cpo_pkg;
    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] CPO_ADDR_AUX_CTRL = 8'h57;
    localparam logic [7:0] CPO_ADDR_PLL_OVR = 8'h58;
    localparam logic [7:0] CPO_ADDR_TRIM = 8'h59;
    localparam logic [7:0] CPO_ADDR_STATUS = 8'h5A;
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] CPO_RST_AUX_CTRL = 8'h00;
    localparam logic [7:0] CPO_RST_PLL_OVR = 8'h00;
    localparam logic [7:0] CPO_RST_TRIM = 8'h00;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CPO_AUX_EN_BIT = 7;
    localparam int CPO_AUX_SEL_LSB = 0;
    localparam int CPO_OVR_EN_BIT = 7;
    localparam int CPO_REF_D_LSB = 4;
    localparam int CPO_REF_C_LSB = 2;
    localparam int CPO_SE_OVR_BIT = 1;
    localparam int CPO_PLL_EN_OVR_BIT = 0;
    localparam int CPO_ST_PLL_EN_BIT = 0;
    localparam int CPO_ST_SE_BIT = 1;
    localparam int CPO_ST_C_ON_BIT = 2;
    localparam int CPO_ST_D_ON_BIT = 3;
    localparam int CPO_ST_AUX_ON_BIT = 7;
    // ----------------------------------------------------------------
    // synchronised pin indices
    // ----------------------------------------------------------------
    localparam int CPO_PIN_PLL_EN = 0;
    localparam int CPO_PIN_SE = 1;
    localparam int CPO_PIN_CFG0 = 2;
    localparam int CPO_PIN_CFG1 = 3;
    localparam int CPO_PIN_TS = 4;
    localparam int CPO_NUM_PINS = 5;
    // ----------------------------------------------------------------
    // half periods in ticks
    // ----------------------------------------------------------------
    localparam logic [5:0] CPO_HALF_UI16 = 6'h08;
    localparam logic [5:0] CPO_HALF_UI32 = 6'h10;
    localparam logic [5:0] CPO_HALF_UI64 = 6'h20;
    localparam logic [5:0] CPO_HALF_DIV1 = 6'h01;
    localparam logic [5:0] CPO_HALF_DIV2 = 6'h02;
    localparam logic [5:0] CPO_HALF_DIV4 = 6'h04;
    // ----------------------------------------------------------------
    // modes
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        CPO_AUX_UI16 = 3'b000,
        CPO_AUX_UI32 = 3'b001,
        CPO_AUX_UI64 = 3'b010,
        CPO_AUX_TS = 3'b011
    } cpo_aux_sel_t;
    typedef enum logic [1:0] {
        CPO_REF_OFF = 2'b00,
        CPO_REF_DIV1 = 2'b01,
        CPO_REF_DIV2 = 2'b10,
        CPO_REF_DIV4 = 2'b11
    } cpo_ref_mode_t;

    function automatic logic [5:0] cpo_ref_half(input logic [1:0] mode);
        case (mode)
            CPO_REF_DIV2: cpo_ref_half = CPO_HALF_DIV2;
            CPO_REF_DIV4: cpo_ref_half = CPO_HALF_DIV4;
            default: cpo_ref_half = CPO_HALF_DIV1;
        endcase
    endfunction : cpo_ref_half
endpackage : cpo_pkg
`default_nettype wire

// File: verification/clock_output_pll_override_ctrl_tb.sv
// self-checking testbench for the clock output and pll override control
`default_nettype none
module clock_output_pll_override_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cpo_pkg::*;
    localparam int WIN = 128;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic ui_tick = 1'b1;
    logic ser_reinit = 1'b0;
    logic ref_tick = 1'b1;
    logic slow_ticks = 1'b0;
    logic pll_enable_pin = 1'b0;
    logic single_ended_ref_pin = 1'b0;
    logic clock_config_pin0 = 1'b0;
    logic clock_config_pin1 = 1'b0;
    logic timestamp_input = 1'b0;
    logic aux_clock_pin;
    logic ref_out_c;
    logic ref_out_d;
    logic pll_enable;
    logic single_ended_ref_clock;
    int bad_count = 0;
    int tests_run = 0;
    int cycles = 0;
    int rises;
    int highs;
    logic [7:0] rnd;

    always #4 clk = ~clk;

    always @(negedge clk)
    begin
        ui_tick <= !slow_ticks || !ui_tick;
        ref_tick <= !slow_ticks || !ref_tick;
    end

    cpo_ctrl uut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ui_tick(ui_tick),
        .ser_reinit(ser_reinit), .ref_tick(ref_tick), .pll_enable_pin(pll_enable_pin),
        .single_ended_ref_pin(single_ended_ref_pin), .clock_config_pin0(clock_config_pin0),
        .clock_config_pin1(clock_config_pin1), .timestamp_input(timestamp_input),
        .aux_clock_pin(aux_clock_pin), .ref_out_c(ref_out_c), .ref_out_d(ref_out_d),
        .pll_enable(pll_enable), .single_ended_ref_clock(single_ended_ref_clock));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic give_verdict();
        if (bad_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        @(negedge clk);
        check(reg_rdata, exp, "register read");
    endtask : rd

    function automatic logic pick(input int which);
        return (which == 0) ? aux_clock_pin : (which == 1) ? ref_out_c : ref_out_d;
    endfunction : pick

    // period in cycles, 0 for a quiet output; ticks arrive every cycle unless slow_ticks is set, then every other cycle
    task automatic clock_is(input int which, input int period, input string what);
        logic prev;
        logic cur;
        rises = 0;
        highs = 0;
        prev = pick(which);
        repeat (WIN)
        begin
            @(negedge clk);
            cur = pick(which);
            if (cur && !prev)
                rises++;
            if (cur)
                highs++;
            prev = cur;
        end
        check(rises, (period == 0) ? 0 : WIN / period, what);
        check(highs, (period == 0) ? 0 : WIN / 2, what);
    endtask : clock_is

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            give_verdict();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        rnd = 8'($urandom(32'hE9FB));
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        rd(CPO_ADDR_AUX_CTRL, CPO_RST_AUX_CTRL);
        rd(CPO_ADDR_PLL_OVR, CPO_RST_PLL_OVR);
        rd(CPO_ADDR_TRIM, CPO_RST_TRIM);
        wr(8'h60, rnd);
        rd(8'h60, 8'h00);
        wr(CPO_ADDR_TRIM, rnd);
        rd(CPO_ADDR_TRIM, rnd);
        wr(CPO_ADDR_AUX_CTRL, 8'h01);
        clock_is(0, 0, "aux off");
        for (int s = 0; s < 3; s++)
        begin
            wr(CPO_ADDR_AUX_CTRL, 8'(s));
            wr(CPO_ADDR_AUX_CTRL, 8'h80 | 8'(s));
            rd(CPO_ADDR_AUX_CTRL, 8'h80 | 8'(s));
            repeat (80) @(negedge clk);
            clock_is(0, 16 << s, "ui clock");
            for (int i = 0; i < 70 && aux_clock_pin !== 1'b1; i++)
                @(negedge clk);
            ser_reinit = 1'b1;
            repeat (3) @(negedge clk);
            check(aux_clock_pin, 1'b0, "reinit");
            ser_reinit = 1'b0;
            repeat (80) @(negedge clk);
            clock_is(0, 16 << s, "restart");
            wr(CPO_ADDR_AUX_CTRL, 8'h00);
        end
        slow_ticks = 1'b1;
        wr(CPO_ADDR_AUX_CTRL, 8'h80);
        wr(CPO_ADDR_PLL_OVR, 8'h94);
        repeat (80) @(negedge clk);
        clock_is(0, 32, "ui ticks counted");
        clock_is(1, 4, "ref ticks counted");
        rd(CPO_ADDR_STATUS, 8'h8C);
        wr(CPO_ADDR_STATUS, 8'hFF);
        rd(CPO_ADDR_STATUS, 8'h8C);
        slow_ticks = 1'b0;
        wr(CPO_ADDR_AUX_CTRL, 8'h00);
        wr(CPO_ADDR_AUX_CTRL, 8'h03);
        wr(CPO_ADDR_AUX_CTRL, 8'h83);
        repeat (6)
        begin
            timestamp_input = 1'($urandom) | ~timestamp_input;
            repeat (6) @(negedge clk);
            check(aux_clock_pin, timestamp_input, "timestamp");
        end
        timestamp_input = 1'b1;
        for (int s = 4; s < 8; s++)
        begin
            wr(CPO_ADDR_AUX_CTRL, 8'h00);
            wr(CPO_ADDR_AUX_CTRL, 8'h80 | 8'(s));
            repeat (8) @(negedge clk);
            clock_is(0, 0, "reserved select");
        end
        for (int i = 0; i < 4; i++)
        begin
            rnd = 8'($urandom) & 8'h03;
            pll_enable_pin = rnd[0];
            single_ended_ref_pin = rnd[1];
            wr(CPO_ADDR_PLL_OVR, 8'h00);
            repeat (6) @(negedge clk);
            check(pll_enable, rnd[0], "pin enable");
            check(single_ended_ref_clock, rnd[1], "pin select");
            pll_enable_pin = ~rnd[0];
            single_ended_ref_pin = ~rnd[1];
            wr(CPO_ADDR_PLL_OVR, 8'h80 | rnd);
            repeat (6) @(negedge clk);
            check(pll_enable, rnd[0], "override enable");
            check(single_ended_ref_clock, rnd[1], "override select");
        end
        for (int c = 0; c < 4; c++)
            for (int d = 0; d < 4; d++)
            begin
                {clock_config_pin1, clock_config_pin0} = 2'($urandom);
                wr(CPO_ADDR_PLL_OVR, 8'h80 | 8'(d << 4) | 8'(c << 2));
                repeat (20) @(negedge clk);
                clock_is(1, (c == 0) ? 0 : 1 << c, "output c");
                clock_is(2, (c == 0 || d == 0) ? 0 : 1 << d, "output d");
            end
        wr(CPO_ADDR_PLL_OVR, 8'h3C);
        rd(CPO_ADDR_PLL_OVR, 8'h3C);
        for (int m = 0; m < 4; m++)
        begin
            {clock_config_pin1, clock_config_pin0} = 2'(m);
            repeat (10) @(negedge clk);
            clock_is(1, (m == 0) ? 0 : 1 << m, "pin c");
            clock_is(2, (m == 0) ? 0 : 1 << m, "pin d");
        end
        give_verdict();
    end
endmodule : clock_output_pll_override_ctrl_tb
`default_nettype wire
